// ### design/motor_fault_map.vh
// register offsets, field positions, reset values and timing of the fault group
`ifndef MOTOR_FAULT_MAP_VH
`define MOTOR_FAULT_MAP_VH

// register offsets (word index on the serial register port)
`define OFS_DRV_OC_STATUS 6'h06
`define OFS_SYS_ERR_STATUS 6'h07
`define OFS_SYNC_PERIOD 6'h0C
`define OFS_FAULT_MODE 6'h10
`define OFS_SYS_FAULT_CTRL 6'h12
`define OFS_RETRY_TIME 6'h16
`define OFS_FAULT_CLEAR 6'h17

// reset values and the system fault control write mask
`define RST_FAULT_MODE 9'h115
`define RST_SYS_FAULT_CTRL 16'h0515
`define WMASK_SYS_FAULT_CTRL 16'h0635
`define RST_QUICK_RETRY 2'h3
`define RST_LONG_RETRY 2'h0

// common field positions
`define BIT_PARITY 15
`define BIT_CFG_FAULT_DIS 8
`define BIT_SER_FAULT_DIS 7
`define OC_SEL_HI 6
`define OC_SEL_LO 4
`define UV_SEL_HI 3
`define UV_SEL_LO 2
`define OT_SEL_HI 1
`define OT_SEL_LO 0
`define BIT_CFG_LOAD_ERR 4
`define BIT_SER_PARITY_ERR 2
`define BIT_SER_CONTENTION 1
`define BIT_SER_FRAMING 0
`define BIT_FAULT_CLEAR 0
`define LONG_SEL_HI 3
`define LONG_SEL_LO 2
`define QUICK_SEL_HI 1
`define QUICK_SEL_LO 0

// overcurrent response codes and the undervoltage/overtemperature slow retry code
`define OC_SLOW_RETRY 3'h0
`define OC_FAST_RETRY 3'h1
`define OC_LATCHED 3'h2
`define OC_REPORT_ONLY 3'h3
`define OC_DISABLED 3'h7
`define UVOT_SLOW_RETRY 2'h0

// timing: clock rate and retry times in microseconds
`define CLK_MHZ 10
`define QUICK_US_0 500
`define QUICK_US_1 1000
`define QUICK_US_2 2000
`define QUICK_US_3 5000
`define LONG_US_0 500000
`define LONG_US_1 1000000
`define LONG_US_2 2000000
`define LONG_US_3 5000000

`endif

// ### design/sync_period_meter.v
// measures the period of the external sync input in clock cycles
`timescale 1ns/10ps
`include "motor_fault_map.vh"

module sync_period_meter #(
    parameter WIDTH = 12
) (
    // clock, reset, enable
    input wire clk_in,
    input wire reset_in,
    input wire ce_in,
    // sync pin, asynchronous
    input wire sync_pin_in,
    // measured period
    output reg [WIDTH-1:0] period_out
);

// ----------------------------------------------------------------
// pin synchroniser and edge finder
// ----------------------------------------------------------------
reg sync_meta_q; // first stage, read only by second
reg sync_s_q; // second stage
reg sync_old_q; // previous synchronised level
reg [WIDTH-1:0] count_q; // cycles since last rising edge
reg seen_q; // one edge seen, so a count is meaningful

wire rise = sync_s_q & ~sync_old_q;
wire at_max = &count_q;

// count between rising edges, saturate on a stopped input
always @(posedge clk_in) begin
    if (reset_in) begin
        sync_meta_q <= 1'b0;
        sync_s_q <= 1'b0;
        sync_old_q <= 1'b0;
        count_q <= {WIDTH{1'b0}};
        seen_q <= 1'b0;
        period_out <= {WIDTH{1'b0}};
    end else if (ce_in) begin
        sync_meta_q <= sync_pin_in;
        sync_s_q <= sync_meta_q;
        sync_old_q <= sync_s_q;
        if (rise) begin
            // first edge only starts the count
            if (seen_q)
                period_out <= count_q;
            seen_q <= 1'b1;
            count_q <= {{(WIDTH-1){1'b0}}, 1'b1};
        end else if (!at_max) begin
            count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
end

endmodule // sync_period_meter

// ### design/motor_fault_regs.v
// status and fault-policy register group of a three-phase motor driver
`timescale 1ns/10ps
`include "motor_fault_map.vh"

module motor_fault_regs #(
    parameter PERIOD_WIDTH = 12,
    parameter TIMER_WIDTH = 26,
    parameter QUICK_CYC_0 = `QUICK_US_0 * `CLK_MHZ,
    parameter QUICK_CYC_1 = `QUICK_US_1 * `CLK_MHZ,
    parameter QUICK_CYC_2 = `QUICK_US_2 * `CLK_MHZ,
    parameter QUICK_CYC_3 = `QUICK_US_3 * `CLK_MHZ,
    parameter LONG_CYC_0 = `LONG_US_0 * `CLK_MHZ,
    parameter LONG_CYC_1 = `LONG_US_1 * `CLK_MHZ,
    parameter LONG_CYC_2 = `LONG_US_2 * `CLK_MHZ,
    parameter LONG_CYC_3 = `LONG_US_3 * `CLK_MHZ
) (
    // clock, reset, enable
    input wire clk_in,
    input wire reset_in,
    input wire ce_in,
    // register port from the serial interface logic
    input wire [5:0] reg_addr_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [15:0] reg_wdata_in,
    input wire serial_check_enable_in,
    output reg [15:0] reg_rdata_out,
    output reg reg_rvalid_out,
    // serial error pulses, same clock
    input wire serial_parity_err_in,
    input wire serial_contention_in,
    input wire serial_framing_in,
    // analog detector levels, asynchronous
    input wire [5:0] overcurrent_detect_in,
    input wire undervoltage_detect_in,
    input wire overtemp_detect_in,
    input wire config_load_err_in,
    input wire sync_pin_in,
    // fault pin and predriver control
    output reg fault_out_n,
    output reg predriver_hiz_out
);

// ----------------------------------------------------------------
// detector synchronisers
// ----------------------------------------------------------------
reg [8:0] det_meta_q; // first stage, read only by second
reg [8:0] det_q; // synchronised detector levels

always @(posedge clk_in) begin
    if (reset_in) begin
        det_meta_q <= 9'h000;
        det_q <= 9'h000;
    end else if (ce_in) begin
        det_meta_q <= {config_load_err_in, overtemp_detect_in,
                       undervoltage_detect_in, overcurrent_detect_in};
        det_q <= det_meta_q;
    end
end

wire [5:0] oc_det = det_q[5:0]; // hs c,b,a at 5..3, ls c,b,a at 2..0
wire uv_det = det_q[6];
wire ot_det = det_q[7];
wire cfg_det = det_q[8];

// ----------------------------------------------------------------
// control registers
// ----------------------------------------------------------------
reg [8:0] fault_mode_q; // bits 8..0 of the fault mode register
reg [15:0] sys_ctrl_q; // writable bits of system fault control
reg [1:0] quick_sel_q; // quick retry time code
reg [1:0] long_sel_q; // long retry time code
reg clear_q; // one-cycle clear strobe, never reads back

wire wr_hit_mode = reg_wr_in && (reg_addr_in == `OFS_FAULT_MODE);
wire wr_hit_ctrl = reg_wr_in && (reg_addr_in == `OFS_SYS_FAULT_CTRL);
wire wr_hit_time = reg_wr_in && (reg_addr_in == `OFS_RETRY_TIME);
wire wr_hit_clr = reg_wr_in && (reg_addr_in == `OFS_FAULT_CLEAR);

wire [2:0] oc_sel = fault_mode_q[`OC_SEL_HI:`OC_SEL_LO];
wire [1:0] uv_sel = fault_mode_q[`UV_SEL_HI:`UV_SEL_LO];
wire [1:0] ot_sel = fault_mode_q[`OT_SEL_HI:`OT_SEL_LO];
wire cfg_dis = fault_mode_q[`BIT_CFG_FAULT_DIS];
wire ser_dis = fault_mode_q[`BIT_SER_FAULT_DIS];

// writes to status registers fall through with no effect
always @(posedge clk_in) begin
    if (reset_in) begin
        fault_mode_q <= `RST_FAULT_MODE;
        sys_ctrl_q <= `RST_SYS_FAULT_CTRL;
        quick_sel_q <= `RST_QUICK_RETRY;
        long_sel_q <= `RST_LONG_RETRY;
        clear_q <= 1'b0;
    end else if (ce_in) begin
        clear_q <= wr_hit_clr && reg_wdata_in[`BIT_FAULT_CLEAR];
        if (wr_hit_mode)
            fault_mode_q <= reg_wdata_in[8:0];
        if (wr_hit_ctrl)
            sys_ctrl_q <= (reg_wdata_in & `WMASK_SYS_FAULT_CTRL) |
                (`RST_SYS_FAULT_CTRL & ~`WMASK_SYS_FAULT_CTRL);
        if (wr_hit_time) begin
            quick_sel_q <= reg_wdata_in[`QUICK_SEL_HI:`QUICK_SEL_LO];
            long_sel_q <= reg_wdata_in[`LONG_SEL_HI:`LONG_SEL_LO];
        end
    end
end

// ----------------------------------------------------------------
// fault classes and policy
// ----------------------------------------------------------------
// overcurrent is armed for codes 0..3; reserved 4..6 act as disabled
wire oc_armed = (oc_sel <= `OC_REPORT_ONLY);
wire oc_retry = (oc_sel == `OC_SLOW_RETRY) ||
                (oc_sel == `OC_FAST_RETRY);
wire oc_hiz = oc_retry || (oc_sel == `OC_LATCHED);

reg [5:0] oc_flag_q; // hs c,b,a then ls c,b,a latches
reg uv_flag_q; // undervoltage latch
reg ot_flag_q; // overtemperature latch
reg cfg_err_q; // config memory load error
reg par_err_q; // serial parity error
reg cont_err_q; // serial contention error
reg serial_framing_error_q; // serial framing error
reg [TIMER_WIDTH-1:0] retry_cnt_q; // retry countdown
reg retry_run_q; // retry timer running
reg retry_done_q; // one-cycle retry expiry

// retry time picks long when any retrying class asks for slow
wire want_long = (oc_flag_q != 6'h00 && oc_sel == `OC_SLOW_RETRY) ||
    (uv_flag_q && uv_sel == `UVOT_SLOW_RETRY) ||
    (ot_flag_q && ot_sel == `UVOT_SLOW_RETRY);
reg [TIMER_WIDTH-1:0] retry_load; // selected retry length

// selection of the retry length from the two timing codes
always @* begin
    retry_load = {TIMER_WIDTH{1'b0}};
    if (want_long) begin
        case (long_sel_q)
            2'h0: retry_load = LONG_CYC_0[TIMER_WIDTH-1:0];
            2'h1: retry_load = LONG_CYC_1[TIMER_WIDTH-1:0];
            2'h2: retry_load = LONG_CYC_2[TIMER_WIDTH-1:0];
            default: retry_load = LONG_CYC_3[TIMER_WIDTH-1:0];
        endcase
    end else begin
        case (quick_sel_q)
            2'h0: retry_load = QUICK_CYC_0[TIMER_WIDTH-1:0];
            2'h1: retry_load = QUICK_CYC_1[TIMER_WIDTH-1:0];
            2'h2: retry_load = QUICK_CYC_2[TIMER_WIDTH-1:0];
            default: retry_load = QUICK_CYC_3[TIMER_WIDTH-1:0];
        endcase
    end
end

wire retry_pending = (oc_retry && oc_flag_q != 6'h00) ||
    uv_flag_q || ot_flag_q;
wire oc_drop = retry_done_q && oc_retry; // retry releases oc latches
wire [5:0] oc_set = oc_det & {6{oc_armed}};

// latches: a detection in the clear cycle wins over the clear
always @(posedge clk_in) begin
    if (reset_in) begin
        oc_flag_q <= 6'h00;
        uv_flag_q <= 1'b0;
        ot_flag_q <= 1'b0;
        cfg_err_q <= 1'b0;
        par_err_q <= 1'b0;
        cont_err_q <= 1'b0;
        serial_framing_error_q <= 1'b0;
    end else if (ce_in) begin
        oc_flag_q <= oc_set |
            (oc_flag_q & ~{6{clear_q | oc_drop}});
        uv_flag_q <= uv_det | (uv_flag_q & ~(clear_q | retry_done_q));
        ot_flag_q <= ot_det | (ot_flag_q & ~(clear_q | retry_done_q));
        cfg_err_q <= cfg_det | (cfg_err_q & ~clear_q);
        par_err_q <= serial_parity_err_in | (par_err_q & ~clear_q);
        cont_err_q <= serial_contention_in | (cont_err_q & ~clear_q);
        serial_framing_error_q <= serial_framing_in | (serial_framing_error_q & ~clear_q);
    end
end

// retry timer: restarts while a detector is still asserted
always @(posedge clk_in) begin
    if (reset_in) begin
        retry_cnt_q <= {TIMER_WIDTH{1'b0}};
        retry_run_q <= 1'b0;
        retry_done_q <= 1'b0;
    end else if (ce_in) begin
        retry_done_q <= 1'b0;
        if (!retry_pending || clear_q) begin
            retry_run_q <= 1'b0;
        end else if (!retry_run_q || (oc_set != 6'h00) || uv_det ||
                     ot_det) begin
            // hold off recovery until the condition has gone
            retry_run_q <= 1'b1;
            retry_cnt_q <= retry_load;
        end else if (retry_cnt_q <= {{(TIMER_WIDTH-1){1'b0}}, 1'b1}) begin
            retry_run_q <= 1'b0;
            retry_done_q <= 1'b1;
        end else begin
            retry_cnt_q <= retry_cnt_q - {{(TIMER_WIDTH-1){1'b0}}, 1'b1};
        end
    end
end

// fault pin and predriver high impedance, both registered
always @(posedge clk_in) begin
    if (reset_in) begin
        fault_out_n <= 1'b1;
        predriver_hiz_out <= 1'b0;
    end else if (ce_in) begin
        fault_out_n <= ~((oc_flag_q != 6'h00 && oc_armed) ||
            uv_flag_q || ot_flag_q ||
            (cfg_err_q && !cfg_dis) ||
            ((par_err_q | cont_err_q | serial_framing_error_q) && !ser_dis));
        predriver_hiz_out <= (oc_flag_q != 6'h00 && oc_hiz) ||
            uv_flag_q || ot_flag_q;
    end
end

// ----------------------------------------------------------------
// sync period measurement
// ----------------------------------------------------------------
wire [PERIOD_WIDTH-1:0] sync_period;

sync_period_meter #(
    .WIDTH(PERIOD_WIDTH)
) u_sync_period (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .sync_pin_in(sync_pin_in),
    .period_out(sync_period)
);

// ----------------------------------------------------------------
// read mux and parity
// ----------------------------------------------------------------
reg [14:0] rd_word; // bits 14..0 of the addressed register

// address decode; unmapped and reserved bits read zero
always @* begin
    rd_word = 15'h0000;
    if (reg_addr_in == `OFS_DRV_OC_STATUS)
        rd_word = {8'h00, oc_flag_q[5:3], 1'b0, oc_flag_q[2:0]};
    else if (reg_addr_in == `OFS_SYS_ERR_STATUS)
        rd_word = {10'h000, cfg_err_q, 1'b0, par_err_q, cont_err_q,
                   serial_framing_error_q};
    else if (reg_addr_in == `OFS_SYNC_PERIOD)
        rd_word = {3'h0, sync_period};
    else if (reg_addr_in == `OFS_FAULT_MODE)
        rd_word = {6'h00, fault_mode_q};
    else if (reg_addr_in == `OFS_SYS_FAULT_CTRL)
        rd_word = sys_ctrl_q[14:0];
    else if (reg_addr_in == `OFS_RETRY_TIME)
        rd_word = {11'h000, long_sel_q, quick_sel_q};
end

// answer registered one cycle after the read strobe
always @(posedge clk_in) begin
    if (reset_in) begin
        reg_rdata_out <= 16'h0000;
        reg_rvalid_out <= 1'b0;
    end else if (ce_in) begin
        reg_rvalid_out <= reg_rd_in;
        if (reg_rd_in)
            reg_rdata_out <= {serial_check_enable_in & (^rd_word),
                              rd_word};
    end
end

endmodule // motor_fault_regs

// ### bench/motor_fault_regs_asserts.sv
// assertions on the register port and fault pins of the fault group
`timescale 1ns/10ps
module motor_fault_regs_asserts (
    // clock, reset, enable
    input wire clk_in,
    input wire reset_in,
    input wire ce_in,
    // register port
    input wire [5:0] reg_addr_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [15:0] reg_wdata_in,
    input wire serial_check_enable_in,
    input wire [15:0] reg_rdata_out,
    input wire reg_rvalid_out,
    // fault sources and fault pins
    input wire [5:0] overcurrent_detect_in,
    input wire undervoltage_detect_in,
    input wire overtemp_detect_in,
    input wire config_load_err_in,
    input wire serial_parity_err_in,
    input wire serial_contention_in,
    input wire serial_framing_in,
    input wire fault_out_n,
    input wire predriver_hiz_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // ----------------------------------------
    // helper state
    // ----------------------------------------
    reg [8:0] mode_q; // shadow of the mode register
    reg [3:0] quiet_q; // cycles with every fault source low
    wire quiet_now = ~(|overcurrent_detect_in | undervoltage_detect_in |
        overtemp_detect_in | config_load_err_in | serial_parity_err_in |
        serial_contention_in | serial_framing_in);
    // quiet count covers the two-stage synchroniser latency
    always @(posedge clk_in) begin
        if (reset_in) begin
            mode_q <= 9'h115;
            quiet_q <= 4'h0;
        end else if (ce_in) begin
            if (reg_wr_in && reg_addr_in == 6'h10) begin
                mode_q <= reg_wdata_in[8:0];
            end
            quiet_q <= !quiet_now ? 4'h0 : (&quiet_q ? quiet_q : quiet_q + 4'h1);
        end
    end
    // ----------------------------------------
    // sequences and properties
    // ----------------------------------------
    sequence read_at(logic [5:0] a);
        ce_in && reg_rd_in && reg_addr_in == a;
    endsequence
    sequence oc_held;
        (|overcurrent_detect_in)[*3];
    endsequence
    AST_RVALID: assert property (ce_in && reg_rd_in |=> reg_rvalid_out)
        else $error("read not answered next cycle");
    AST_NO_SPURIOUS: assert property (!(ce_in && reg_rd_in) |=> !reg_rvalid_out)
        else $error("answer without read");
    AST_PARITY: assert property (reg_rvalid_out |-> reg_rdata_out[15] ==
        ($past(serial_check_enable_in) & ^reg_rdata_out[14:0]))
        else $error("bad parity bit");
    AST_DRV_RSV: assert property (read_at(6'h06) |=>
        reg_rdata_out[14:7] == 8'h00 && !reg_rdata_out[3])
        else $error("driver status reserved bits set");
    AST_SYS_RSV: assert property (read_at(6'h07) |=>
        reg_rdata_out[14:5] == 10'h000 && !reg_rdata_out[3])
        else $error("system status reserved bits set");
    AST_SYNC_RSV: assert property (read_at(6'h0C) |=>
        reg_rdata_out[14:12] == 3'h0)
        else $error("sync period reserved bits set");
    AST_MODE_READ: assert property (read_at(6'h10) |=>
        reg_rdata_out[14:0] == {6'h00, $past(mode_q)})
        else $error("mode register read mismatch");
    AST_OC_REPORT: assert property (oc_held ##0 mode_q[6:4] <= 3'h3 |->
        ##[0:4] !fault_out_n)
        else $error("overcurrent not reported");
    AST_CLEAR: assert property (ce_in && reg_wr_in && reg_addr_in == 6'h17 &&
        reg_wdata_in[0] && quiet_q >= 4'h4 |-> ##[1:4] fault_out_n)
        else $error("fault clear did not release fault pin");
    AST_HIZ_REPORT: assert property (predriver_hiz_out |-> !fault_out_n)
        else $error("high impedance without fault report");
endmodule // motor_fault_regs_asserts

// ### bench/host_model.sv
// host side model: register port master and sync pulse source
`timescale 1ns/10ps
module host_model (
    // clock
    input wire clk_in,
    // register port toward the device
    output reg [5:0] addr_out = 6'h00,
    output reg wr_out = 1'b0,
    output reg rd_out = 1'b0,
    output reg [15:0] wdata_out = 16'h0000,
    input wire [15:0] rdata_in,
    input wire rvalid_in,
    // sync pin source
    input wire sync_run_in,
    output reg sync_out = 1'b0
);
    // 800 ns sync, off phase with the clock; rests low when stopped
    initial begin
        #37;
        forever begin
            #400 sync_out = sync_run_in ? ~sync_out : 1'b0;
        end
    end
    // one write strobe, then the data lines show the inverse
    task wr(input [5:0] a, input [15:0] d);
        begin
            @(posedge clk_in);
            addr_out <= a;
            wdata_out <= d;
            wr_out <= 1'b1;
            @(posedge clk_in);
            wr_out <= 1'b0;
            wdata_out <= ~d;
            repeat (3) @(posedge clk_in);
        end
    endtask
    // answer is due exactly one cycle after the read edge
    task rd(input [5:0] a, output [15:0] d);
        begin
            @(posedge clk_in);
            addr_out <= a;
            rd_out <= 1'b1;
            @(posedge clk_in);
            rd_out <= 1'b0;
            #1;
            d = (rvalid_in === 1'b1) ? rdata_in : 16'hXXXX;
        end
    endtask
endmodule // host_model

// ### bench/tb_top.sv
// self-checking bench for the motor fault register group
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
    err_count++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module tb_top;
    // ----------------------------------------
    // stimulus and wiring
    // ----------------------------------------
    reg clk_in = 1'b0;
    reg reset_in = 1'b1;
    reg ser_chk = 1'b0;
    reg ce = 1'b1; // clock enable, dropped once to check the freeze
    reg [5:0] oc_det = 6'h00;
    reg uv_det = 1'b0, ot_det = 1'b0, cfg_err = 1'b0, sync_run = 1'b0;
    reg par_err = 1'b0, cont_err = 1'b0, serial_framing_error = 1'b0;
    wire [5:0] addr;
    wire [15:0] wdata, rdata;
    wire wr, rd, rvalid, sync_pin, fault_n, hiz;
    int err_count = 0, num_checks = 0, cycles = 0, i;
    always #50 clk_in = ~clk_in;
    host_model i_host (.clk_in(clk_in), .addr_out(addr), .wr_out(wr),
        .rd_out(rd), .wdata_out(wdata), .rdata_in(rdata), .rvalid_in(rvalid),
        .sync_run_in(sync_run), .sync_out(sync_pin));
    // short retry lengths keep the run brief
    motor_fault_regs #(.QUICK_CYC_0(20), .QUICK_CYC_3(50),
        .LONG_CYC_0(100)) i_dut (
        .clk_in(clk_in), .reset_in(reset_in), .ce_in(ce),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_wdata_in(wdata), .serial_check_enable_in(ser_chk),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .serial_parity_err_in(par_err), .serial_contention_in(cont_err),
        .serial_framing_in(serial_framing_error), .overcurrent_detect_in(oc_det),
        .undervoltage_detect_in(uv_det), .overtemp_detect_in(ot_det),
        .config_load_err_in(cfg_err), .sync_pin_in(sync_pin),
        .fault_out_n(fault_n), .predriver_hiz_out(hiz));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task final_report;
        if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task rdchk(input [5:0] a, input [15:0] ex);
        logic [15:0] d;
        begin
            i_host.rd(a, d);
            `CHK("rdata", ex, d)
        end
    endtask
    task pinchk(input logic f, input logic h);
        `CHK("fault_out_n", f, fault_n)
        `CHK("predriver_hiz_out", h, hiz)
    endtask
    // detector held three cycles, long enough for the synchroniser
    task oc_pulse(input [5:0] m);
        @(posedge clk_in) oc_det <= m;
        repeat (3) @(posedge clk_in);
        oc_det <= 6'h00;
        repeat (4) @(posedge clk_in);
    endtask
    task ser_pulse(input [2:0] m, input logic c);
        @(posedge clk_in) {par_err, cont_err, serial_framing_error} <= m;
        cfg_err <= c;
        @(posedge clk_in) {par_err, cont_err, serial_framing_error} <= 3'h0;
        repeat (2) @(posedge clk_in);
        cfg_err <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask
    // hang guard, well above the expected run length
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_count++;
            final_report();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        rdchk(6'h10, 16'h0115);
        rdchk(6'h12, 16'h0515);
        rdchk(6'h16, 16'h0003);
        rdchk(6'h3F, 16'h0000);
        i_host.wr(6'h07, 16'hFFFF);
        i_host.wr(6'h06, 16'hFFFF);
        i_host.wr(6'h0C, 16'hFFFF);
        rdchk(6'h07, 16'h0000);
        rdchk(6'h06, 16'h0000);
        rdchk(6'h0C, 16'h0000);
        i_host.wr(6'h10, 16'hFFFF);
        rdchk(6'h10, 16'h01FF);
        i_host.wr(6'h10, 16'h0115);
        // each transistor flag with fast retry, then auto recovery
        for (i = 0; i < 6; i++) begin
            oc_pulse(6'h01 << i);
            rdchk(6'h06, 16'h0001 << (i < 3 ? i : i + 1));
            pinchk(1'b0, 1'b1);
            repeat (70) @(posedge clk_in);
            rdchk(6'h06, 16'h0000);
        end
        i_host.wr(6'h16, 16'h0000);
        oc_pulse(6'h01);
        repeat (35) @(posedge clk_in);
        rdchk(6'h06, 16'h0000);
        i_host.wr(6'h10, 16'h0105);
        oc_pulse(6'h01);
        repeat (60) @(posedge clk_in);
        rdchk(6'h06, 16'h0001);
        repeat (60) @(posedge clk_in);
        rdchk(6'h06, 16'h0000);
        i_host.wr(6'h10, 16'h0125);
        oc_pulse(6'h02);
        repeat (150) @(posedge clk_in);
        rdchk(6'h06, 16'h0002);
        pinchk(1'b0, 1'b1);
        i_host.wr(6'h17, 16'h0001);
        rdchk(6'h06, 16'h0000);
        rdchk(6'h17, 16'h0000);
        pinchk(1'b1, 1'b0);
        i_host.wr(6'h10, 16'h0135);
        oc_pulse(6'h08);
        rdchk(6'h06, 16'h0010);
        pinchk(1'b0, 1'b0);
        i_host.wr(6'h17, 16'h0001);
        // reserved code 5 and disabled code 7 both ignore detection
        for (i = 5; i < 8; i += 2) begin
            i_host.wr(6'h10, 16'h0105 | (i << 4));
            oc_pulse(6'h3F);
            rdchk(6'h06, 16'h0000);
            pinchk(1'b1, 1'b0);
        end
        i_host.wr(6'h10, 16'h0115);
        ser_pulse(3'h7, 1'b1);
        rdchk(6'h07, 16'h0017);
        `CHK("fault_out_n", 1'b0, fault_n)
        i_host.wr(6'h17, 16'h0001);
        rdchk(6'h07, 16'h0000);
        i_host.wr(6'h10, 16'h0195);
        ser_pulse(3'h1, 1'b1);
        rdchk(6'h07, 16'h0011);
        `CHK("fault_out_n", 1'b1, fault_n)
        i_host.wr(6'h17, 16'h0001);
        i_host.wr(6'h10, 16'h0015);
        ser_pulse(3'h0, 1'b1);
        `CHK("fault_out_n", 1'b0, fault_n)
        i_host.wr(6'h17, 16'h0001);
        i_host.wr(6'h10, 16'h0115);
        @(posedge clk_in) {uv_det, ot_det} <= 2'h3;
        repeat (3) @(posedge clk_in);
        {uv_det, ot_det} <= 2'h0;
        repeat (4) @(posedge clk_in);
        pinchk(1'b0, 1'b1);
        repeat (70) @(posedge clk_in);
        pinchk(1'b1, 1'b0);
        sync_run <= 1'b1;
        repeat (40) @(posedge clk_in);
        rdchk(6'h0C, 16'h0008);
        ser_chk <= 1'b1;
        rdchk(6'h0C, 16'h8008);
        rdchk(6'h12, 16'h8515);
        rdchk(6'h10, 16'h0115);
        // with the enable low a mode write must not land
        @(posedge clk_in);
        ce <= 1'b0;
        i_host.wr(6'h10, 16'h0000);
        ce <= 1'b1;
        rdchk(6'h10, 16'h0115);
        final_report();
    end
endmodule // tb_top
bind motor_fault_regs motor_fault_regs_asserts u_chk (.clk_in(clk_in),
    .reset_in(reset_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .serial_check_enable_in(serial_check_enable_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .overcurrent_detect_in(overcurrent_detect_in),
    .undervoltage_detect_in(undervoltage_detect_in),
    .overtemp_detect_in(overtemp_detect_in),
    .config_load_err_in(config_load_err_in),
    .serial_parity_err_in(serial_parity_err_in),
    .serial_contention_in(serial_contention_in),
    .serial_framing_in(serial_framing_in), .fault_out_n(fault_out_n),
    .predriver_hiz_out(predriver_hiz_out));
